// ---- smsc_pkg.sv ----
// Package with constants and types for the meter port splitter controller
// Function
// RL1 - Free mode: request every second, forward bytes
// RL2 - Free mode frames ignore downstream request
// RL3 - Buffered mode: send telegram on request
// RL4 - Follow mode relays request; partner requests secondly
// RL5 - Follow mode passes bytes through unbuffered
// RL6 - Booting shows steady red LED
// RL7 - Receiving and network ready shows green
// RL8 - Short press: soft reset, reconnect
// RL9 - Hold over 4 s: factory defaults
// RL10 - Three failed retries: link-local address
// RL11 - Two-bit mode input, one path active
package smsc_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  localparam int unsigned REQ_PERIOD_MS = 1000;
  localparam int unsigned REQ_PERIOD_CYC = CLK_HZ / 1000 * REQ_PERIOD_MS;
  localparam int unsigned HOLD_S = 4;
  localparam int unsigned HOLD_CYC = CLK_HZ * HOLD_S;
  localparam int unsigned RX_FRESH_MS = 2000;
  localparam int unsigned RX_FRESH_CYC = CLK_HZ / 1000 * RX_FRESH_MS;
  localparam logic [1:0] DHCP_RETRIES = 2'h3;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned TEL_DEPTH = 1024;
  localparam logic [7:0] TEL_END_CHAR = 8'h21;

  typedef enum logic [1:0]
  {
    SMSC_MODE_FREE = 2'b01,
    SMSC_MODE_BUFFER = 2'b10,
    SMSC_MODE_FOLLOW = 2'b11,
    SMSC_MODE_OFF = 2'b00
  } smsc_mode_e;

  typedef enum logic [1:0]
  {
    SMSC_BTN_IDLE = 2'b00,
    SMSC_BTN_SHORT = 2'b01,
    SMSC_BTN_LONG = 2'b10
  } smsc_btn_e;

  typedef struct packed
  {
    logic red;
    logic green;
    logic blue;
  } smsc_led_s;

  typedef struct packed
  {
    logic valid;
    logic [7:0] data;
  } smsc_byte_s;
endpackage : smsc_pkg

// ---- smsc_fifo.sv ----
// Small valid/ready FIFO for forwarded bytes
`timescale 1ns/1ps
`default_nettype none
module smsc_fifo
  import smsc_pkg::*;
#(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  // Pointer and count next values
  always_comb
  begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
    next_count = count;
    if (push && !pop)
    begin
      next_count = (AW+1)'(count + 1'b1);
    end
    else if (pop && !push)
    begin
      next_count = (AW+1)'(count - 1'b1);
    end
  end

  // Registers; storage has no reset
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
endmodule : smsc_fifo
`default_nettype wire

// ---- smsc_tel_mem.sv ----
// Telegram store with registered read data
`timescale 1ns/1ps
`default_nettype none
module smsc_tel_mem
  import smsc_pkg::*;
#(
  parameter int unsigned DEPTH = 1024
)
(
  // Clock
  input wire logic mclk,
  // Write port
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  // Read port
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [DEPTH];

  // Single-port style write, registered read
  always_ff @(posedge mclk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule : smsc_tel_mem
`default_nettype wire

// ---- smsc_ctrl.sv ----
// Meter port splitter controller: forwarding, LED, button, address fallback
`timescale 1ns/1ps
`default_nettype none
module smsc_ctrl
  import smsc_pkg::*;
#(
  parameter int unsigned REQ_CYC = REQ_PERIOD_CYC,
  parameter int unsigned HOLD_CYCLES = HOLD_CYC,
  parameter int unsigned FRESH_CYC = RX_FRESH_CYC,
  parameter int unsigned TEL_WORDS = TEL_DEPTH
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Configuration
  input wire logic [1:0] fwd_mode,
  input wire logic dhcp_enable,
  // Upstream meter port
  input wire logic up_rx_valid,
  input wire logic [7:0] up_rx_data,
  output logic upstream_meter_port_req,
  // Downstream meter port
  input wire logic downstream_meter_port_req,
  output logic dn_tx_valid,
  output logic [7:0] dn_tx_data,
  input wire logic dn_tx_ready,
  // System status
  input wire logic boot_done,
  input wire logic net_ready,
  input wire logic dhcp_attempt_fail,
  // Button
  input wire logic button_pressed,
  // Actions and indicators
  output logic soft_reset,
  output logic factory_reset,
  output logic dhcp_retry,
  output logic link_local_assign,
  output smsc_led_s led
);
  localparam int unsigned TW = $clog2(TEL_WORDS);

  // Shared state
  logic [31:0] req_cnt, next_req_cnt;
  logic [31:0] hold_cnt, next_hold_cnt;
  logic [31:0] fresh_cnt, next_fresh_cnt;
  logic [1:0] retry_cnt, next_retry_cnt;
  logic btn_q, hold_long, next_hold_long;
  logic up_req, next_up_req;
  logic soft_q, next_soft_q, fact_q, next_fact_q;
  logic retry_q, next_retry_q, ll_q, next_ll_q;
  smsc_led_s led_q, next_led_q;
  smsc_mode_e mode;

  // Telegram buffer state
  logic [TW-1:0] wr_addr, next_wr_addr, tel_len, next_tel_len;
  logic [TW-1:0] rd_addr, next_rd_addr;
  logic tel_ok, next_tel_ok, sending, next_sending, rd_vld, next_rd_vld;
  logic [7:0] mem_rd;
  logic [TW-1:0] mem_raddr;
  logic mem_we;

  // FIFO fill side
  logic f_in_valid, f_in_ready;
  logic [7:0] f_in_data;

  assign mode = smsc_mode_e'(fwd_mode); // RL11

  smsc_tel_mem #(.DEPTH(TEL_WORDS)) u_mem
  (
    .mclk(mclk),
    .wr_en(mem_we),
    .wr_addr(wr_addr),
    .wr_data(up_rx_data),
    .rd_addr(mem_raddr),
    .rd_data(mem_rd)
  );

  smsc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo
  (
    .mclk(mclk),
    .rst(rst),
    .in_valid(f_in_valid),
    .in_data(f_in_data),
    .in_ready(f_in_ready),
    .out_valid(dn_tx_valid),
    .out_data(dn_tx_data),
    .out_ready(dn_tx_ready)
  );

  // Request line: periodic in free mode, relayed in follow mode
  always_comb
  begin
    next_req_cnt = req_cnt;
    next_up_req = 1'b0;
    case (mode)
      SMSC_MODE_FREE:
      begin
        next_req_cnt = (req_cnt >= REQ_CYC - 1) ? 32'h0 : req_cnt + 32'h1;
        next_up_req = (req_cnt == 32'h0); // RL1
      end
      SMSC_MODE_FOLLOW:
      begin
        next_req_cnt = 32'h0;
        next_up_req = downstream_meter_port_req; // RL4
      end
      default:
      begin
        next_req_cnt = (req_cnt >= REQ_CYC - 1) ? 32'h0 : req_cnt + 32'h1;
        next_up_req = (req_cnt == 32'h0) && (mode == SMSC_MODE_BUFFER);
      end
    endcase
  end

  // Telegram capture and replay; FIFO fed by one path only
  always_comb
  begin
    next_wr_addr = wr_addr;
    next_tel_len = tel_len;
    next_tel_ok = tel_ok;
    next_rd_addr = rd_addr;
    next_sending = sending;
    next_rd_vld = 1'b0;
    mem_raddr = rd_addr;
    mem_we = 1'b0;
    f_in_valid = 1'b0;
    f_in_data = up_rx_data;
    case (mode)
      SMSC_MODE_FREE, SMSC_MODE_FOLLOW:
      begin
        // Bytes go straight through; a full FIFO drops them since the meter cannot stall
        f_in_valid = up_rx_valid; // RL1 RL2 RL5
        next_sending = 1'b0;
      end
      SMSC_MODE_BUFFER:
      begin
        // Capture is blocked during replay so the sent telegram stays whole
        if (up_rx_valid && !sending)
        begin
          mem_we = 1'b1;
          next_wr_addr = TW'(wr_addr + 1'b1);
          if (up_rx_data == TEL_END_CHAR)
          begin
            next_tel_len = TW'(wr_addr + 1'b1);
            next_tel_ok = 1'b1;
            next_wr_addr = '0;
          end
        end
        if (!sending && tel_ok && downstream_meter_port_req)
        begin
          next_sending = 1'b1; // RL3
          next_rd_addr = '0;
        end
        if (sending)
        begin
          f_in_data = mem_rd;
          f_in_valid = rd_vld;
          if (!rd_vld || f_in_ready)
          begin
            if (rd_addr == tel_len)
            begin
              next_sending = rd_vld ? 1'b0 : sending;
            end
            else
            begin
              next_rd_addr = TW'(rd_addr + 1'b1);
              next_rd_vld = 1'b1;
            end
          end
          else
          begin
            // Stalled: re-read the presented byte, else the read port runs one ahead and drops it
            next_rd_vld = rd_vld;
            mem_raddr = TW'(rd_addr - 1'b1);
          end
          if (rd_vld && f_in_ready && rd_addr == tel_len)
          begin
            next_sending = 1'b0;
          end
        end
      end
      default:
      begin
        next_sending = 1'b0;
      end
    endcase
  end

  // Button timing, LED and address fallback
  always_comb
  begin
    next_hold_cnt = hold_cnt;
    next_hold_long = hold_long;
    next_soft_q = 1'b0;
    next_fact_q = 1'b0;
    if (button_pressed)
    begin
      if (hold_cnt < HOLD_CYCLES)
      begin
        next_hold_cnt = hold_cnt + 32'h1;
      end
      else if (!hold_long)
      begin
        next_hold_long = 1'b1;
        next_fact_q = 1'b1; // RL9
      end
    end
    else
    begin
      next_hold_cnt = 32'h0;
      next_hold_long = 1'b0;
      next_soft_q = btn_q && !hold_long; // RL8
    end
    next_fresh_cnt = up_rx_valid ? FRESH_CYC : (fresh_cnt != 32'h0 ? fresh_cnt - 32'h1 : 32'h0);
    next_led_q = '{red: !boot_done, green: 1'b0, blue: 1'b0}; // RL6
    if (boot_done && net_ready && fresh_cnt != 32'h0)
    begin
      next_led_q = '{red: 1'b0, green: 1'b1, blue: 1'b0}; // RL7
    end
    next_retry_cnt = retry_cnt;
    next_retry_q = 1'b0;
    next_ll_q = 1'b0;
    if (soft_q || !dhcp_enable)
    begin
      next_retry_cnt = 2'h0;
      next_retry_q = soft_q && dhcp_enable; // Reconnect after soft reset
    end
    else if (dhcp_attempt_fail)
    begin
      if (retry_cnt == DHCP_RETRIES)
      begin
        next_ll_q = 1'b1; // RL10
        next_retry_cnt = 2'h0;
      end
      else
      begin
        next_retry_cnt = 2'(retry_cnt + 1'b1);
        next_retry_q = 1'b1;
      end
    end
  end

  // All registers
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      req_cnt <= 32'h0;
      up_req <= 1'b0;
      wr_addr <= '0;
      tel_len <= '0;
      tel_ok <= 1'b0;
      rd_addr <= '0;
      sending <= 1'b0;
      rd_vld <= 1'b0;
      hold_cnt <= 32'h0;
      hold_long <= 1'b0;
      btn_q <= 1'b0;
      soft_q <= 1'b0;
      fact_q <= 1'b0;
      fresh_cnt <= 32'h0;
      led_q <= '{red: 1'b1, green: 1'b0, blue: 1'b0};
      retry_cnt <= 2'h0;
      retry_q <= 1'b0;
      ll_q <= 1'b0;
    end
    else
    begin
      req_cnt <= next_req_cnt;
      up_req <= next_up_req;
      wr_addr <= next_wr_addr;
      tel_len <= next_tel_len;
      tel_ok <= next_tel_ok;
      rd_addr <= next_rd_addr;
      sending <= next_sending;
      rd_vld <= next_rd_vld;
      hold_cnt <= next_hold_cnt;
      hold_long <= next_hold_long;
      btn_q <= button_pressed;
      soft_q <= next_soft_q;
      fact_q <= next_fact_q;
      fresh_cnt <= next_fresh_cnt;
      led_q <= next_led_q;
      retry_cnt <= next_retry_cnt;
      retry_q <= next_retry_q;
      ll_q <= next_ll_q;
    end
  end

  assign upstream_meter_port_req = up_req;
  assign soft_reset = soft_q;
  assign factory_reset = fact_q;
  assign dhcp_retry = retry_q;
  assign link_local_assign = ll_q;
  assign led = led_q;

  // Checks
  chk_follow_relay: assert property (@(posedge mclk) disable iff (rst) // RL4
    (mode == SMSC_MODE_FOLLOW && $stable(mode)) |=> upstream_meter_port_req == $past(downstream_meter_port_req))
    else $error("request not relayed");
  chk_boot_red: assert property (@(posedge mclk) disable iff (rst) // RL6
    !boot_done |=> led.red && !led.green)
    else $error("LED not red while booting");
  chk_green_ok: assert property (@(posedge mclk) disable iff (rst) // RL7
    (boot_done && net_ready && up_rx_valid) ##1 (boot_done && net_ready) |=> led.green && !led.red)
    else $error("LED not green while receiving");
  chk_factory_pulse: assert property (@(posedge mclk) disable iff (rst) // RL9
    factory_reset |=> !factory_reset && !soft_reset)
    else $error("factory reset not one pulse");
  chk_short_release: assert property (@(posedge mclk) disable iff (rst) // RL8
    ($fell(button_pressed) && !hold_long) |=> soft_reset)
    else $error("short press missed soft reset");
  chk_long_no_soft: assert property (@(posedge mclk) disable iff (rst) // RL9
    ($fell(button_pressed) && hold_long) |=> !soft_reset)
    else $error("long press gave soft reset");
  chk_fallback: assert property (@(posedge mclk) disable iff (rst) // RL10
    (dhcp_enable && !soft_q && dhcp_attempt_fail && retry_cnt == DHCP_RETRIES) |=> link_local_assign)
    else $error("no link-local fallback");
  chk_buf_idle: assert property (@(posedge mclk) disable iff (rst) // RL3
    (mode == SMSC_MODE_BUFFER && !sending && !tel_ok) |-> !f_in_valid)
    else $error("buffered output without telegram");
  chk_one_path: assert property (@(posedge mclk) disable iff (rst) // RL11
    (mode != SMSC_MODE_BUFFER) |-> !mem_we)
    else $error("two paths active");
  chk_free_req: assert property (@(posedge mclk) disable iff (rst) // RL1
    upstream_meter_port_req && mode == SMSC_MODE_FREE && $stable(mode) |=> !upstream_meter_port_req)
    else $error("free request not a pulse");
endmodule : smsc_ctrl
`default_nettype wire

// ---- smsc_meter_model.sv ----
// Behavioural meter: answers each request made while idle with a short telegram
`timescale 1ns/1ps
`default_nettype none
module smsc_meter_model
  import smsc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Meter port
  input wire logic req,
  output logic rx_valid,
  output logic [7:0] rx_data
);
  logic [3:0] step;
  logic [7:0] last;
  logic [7:0] nxt;

  // Byte order A, B, C, then end char
  assign nxt = (step == 4'h7) ? TEL_END_CHAR : 8'h41 + {5'h00, step[3:1]};

  // One byte every other cycle; idle line never repeats the last byte
  always @(posedge mclk)
  begin
    rx_valid <= 1'b0;
    rx_data <= ~last;
    if (rst)
    begin
      step <= 4'h0;
      last <= 8'h00;
    end
    else if (step == 4'h0)
      step <= req ? 4'h1 : 4'h0;
    else
    begin
      step <= (step == 4'h8) ? 4'h0 : step + 4'h1;
      if (step[0])
      begin
        rx_valid <= 1'b1;
        rx_data <= nxt;
        last <= nxt;
      end
    end
  end
endmodule : smsc_meter_model
`default_nettype wire

// ---- smsc_ctrl_tb_top.sv ----
// Self-checking testbench for the meter port splitter controller
`timescale 1ns/1ps
`default_nettype none
module smsc_ctrl_tb_top;
  import smsc_pkg::*;
  localparam int REQ = 100;
  typedef struct {logic [1:0] mode; logic pulse; int exp;} smsc_row_s;

  logic mclk, rst, dhcp_enable, up_rx_valid, upstream_meter_port_req, downstream_meter_port_req;
  logic dn_tx_valid, dn_tx_ready, boot_done, net_ready, dhcp_attempt_fail, button_pressed;
  logic soft_reset, factory_reset, dhcp_retry, link_local_assign;
  logic [1:0] fwd_mode;
  logic [7:0] up_rx_data, dn_tx_data;
  smsc_led_s led;
  int error_cnt = 0;
  int checked = 0;
  int rc, lc;
  logic [7:0] got [$];
  int req_t [$];
  // Forwarding cases: mode, downstream request pulse, bytes expected
  smsc_row_s rows [3] = '{'{SMSC_MODE_FREE, 1'b0, 4}, '{SMSC_MODE_FOLLOW, 1'b1, 4}, '{SMSC_MODE_OFF, 1'b1, 0}};

  smsc_ctrl #(.REQ_CYC(REQ), .HOLD_CYCLES(50), .FRESH_CYC(200), .TEL_WORDS(16)) smsc_ctrl_i (
    .mclk(mclk), .rst(rst), .fwd_mode(fwd_mode), .dhcp_enable(dhcp_enable),
    .up_rx_valid(up_rx_valid), .up_rx_data(up_rx_data), .upstream_meter_port_req(upstream_meter_port_req),
    .downstream_meter_port_req(downstream_meter_port_req), .dn_tx_valid(dn_tx_valid),
    .dn_tx_data(dn_tx_data), .dn_tx_ready(dn_tx_ready), .boot_done(boot_done), .net_ready(net_ready),
    .dhcp_attempt_fail(dhcp_attempt_fail), .button_pressed(button_pressed), .soft_reset(soft_reset),
    .factory_reset(factory_reset), .dhcp_retry(dhcp_retry), .link_local_assign(link_local_assign), .led(led));

  smsc_meter_model smsc_meter_model_i (.mclk(mclk), .rst(rst), .req(upstream_meter_port_req),
    .rx_valid(up_rx_valid), .rx_data(up_rx_data));

  // Clock
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic print_verdict();
    $display("Counts: %0d checks, %0d mismatches", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict

  task automatic do_reset();
    rst <= 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    #1;
  endtask : do_reset

  // Runs ncyc cycles, gathering accepted bytes; sink stalls half the time
  task automatic run(input logic pulse, input int ncyc);
    logic pre, acc;
    logic [7:0] d;
    got.delete();
    req_t.delete();
    for (int i = 0; i < ncyc; i++)
    begin
      pre = downstream_meter_port_req;
      acc = dn_tx_valid && dn_tx_ready;
      d = dn_tx_data;
      @(posedge mclk);
      downstream_meter_port_req <= pulse && i == 0;
      dn_tx_ready <= i[1];
      #1;
      if (acc)
        got.push_back(d);
      if (upstream_meter_port_req === 1'b1)
        req_t.push_back(i);
      if (fwd_mode == SMSC_MODE_FOLLOW)
        chk(8'(upstream_meter_port_req), 8'(pre));
    end
  endtask : run

  task automatic chk_bytes(input int exp);
    chk(8'(exp == 0 ? got.size() == 0 : got.size() >= exp), 8'h01);
    for (int k = 0; k < exp && k < got.size(); k++)
      chk(got[k], k == 3 ? TEL_END_CHAR : 8'h41 + 8'(k));
  endtask : chk_bytes

  // Presses the button for hold cycles; collects soft, factory, retry pulses
  task automatic press(input int hold, input logic [7:0] exp);
    logic [7:0] seen;
    seen = 8'h00;
    button_pressed <= 1'b1;
    for (int i = 0; i < hold + 10; i++)
    begin
      @(posedge mclk);
      if (i == hold)
        button_pressed <= 1'b0;
      #1;
      seen = seen | {5'h00, soft_reset === 1'b1, factory_reset === 1'b1, dhcp_retry === 1'b1};
    end
    chk(seen, exp);
    $display("Button hold %0d done", hold);
  endtask : press

  // Main sequence
  initial
  begin
    rst = 1'b1;
    fwd_mode = SMSC_MODE_OFF;
    dhcp_enable = 1'b1;
    downstream_meter_port_req = 1'b0;
    dn_tx_ready = 1'b0;
    boot_done = 1'b0;
    net_ready = 1'b0;
    dhcp_attempt_fail = 1'b0;
    button_pressed = 1'b0;
    do_reset();
    @(posedge mclk);
    #1;
    chk(8'(led), 8'h04);
    foreach (rows[r])
    begin
      fwd_mode <= rows[r].mode;
      do_reset();
      run(rows[r].pulse, 220);
      chk_bytes(rows[r].exp);
      if (rows[r].mode == SMSC_MODE_FREE)
        chk(8'(req_t.size() > 1 ? req_t[1] - req_t[0] : 0), 8'(REQ));
      $display("Mode row %0d done", r);
    end
    // Buffered: nothing leaves until the sink asks, then one whole telegram
    fwd_mode <= SMSC_MODE_BUFFER;
    boot_done <= 1'b1;
    net_ready <= 1'b1;
    do_reset();
    run(1'b0, 220);
    chk_bytes(0);
    run(1'b1, 60);
    chk_bytes(4);
    chk(8'(led), 8'h02);
    $display("Buffered test done");
    press(10, 8'h05);
    press(60, 8'h02);
    // Four failed attempts: three retries, then link-local fallback
    do_reset();
    rc = 0;
    lc = 0;
    for (int i = 0; i < 48; i++)
    begin
      @(posedge mclk);
      dhcp_attempt_fail <= (i % 8 == 1) && i < 32;
      #1;
      rc += int'(dhcp_retry === 1'b1);
      lc += int'(link_local_assign === 1'b1);
    end
    chk(8'(rc), 8'h03);
    chk(8'(lc), 8'h01);
    $display("Address fallback test done");
    // Automatic configuration off: failures give neither retry nor fallback
    dhcp_enable <= 1'b0;
    rc = 0;
    lc = 0;
    for (int i = 0; i < 40; i++)
    begin
      @(posedge mclk);
      dhcp_attempt_fail <= (i % 8 == 1);
      #1;
      rc += int'(dhcp_retry === 1'b1);
      lc += int'(link_local_assign === 1'b1);
    end
    chk(8'(rc + lc), 8'h00);
    $display("Address disabled test done");
    print_verdict();
  end
endmodule : smsc_ctrl_tb_top
`default_nettype wire
